// >>> core/alarm_error_indication.sv
// alarm LED, relay, process data, coded analog level and timestamp clock
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "alarm_consts.svh"

module alarm_error_indication #(
  parameter int unsigned TICK_CYCLES = `TICK_NS / `CLK_PERIOD_NS
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [9:0] ERROR_CODE,
  input wire logic ERROR_VALID,
  input wire logic START,
  input wire logic [11:0] TEMP_LEVEL,
  input wire logic LOG_STROBE,
  input wire logic CLOCK_LOST,
  output logic ALARM_LED,
  output logic ALARM_RELAY,
  output logic [11:0] ACTUAL_LEVEL,
  output alarm_pkg::pd_t PROCESS_DATA,
  output logic ERROR_CLEAR,
  output logic [31:0] LOG_STAMP,
  output logic LOG_STAMP_OK,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  alarm_pkg::state_t st;
  alarm_pkg::state_t next_st;
  alarm_pkg::class_t cur;
  logic warn_cls;
  logic fault_now;
  logic tick;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  // map a three-digit code to its indication class and level
  function automatic alarm_pkg::class_t classify(input logic [9:0] code);
    alarm_pkg::class_t c;
    c.cls = alarm_pkg::CLS_FAULT;
    c.level = `LVL_4V66;
    case (code)
      10'h065: c.level = `LVL_0V66; // 101
      10'h066: c.level = `LVL_1V33; // 102
      10'h067: c.level = `LVL_2V00; // 103
      10'h06b, 10'h06c, 10'h133, 10'h134, 10'h135, 10'h136:
        c.level = `LVL_2V66;
      10'h0c9, 10'h0ca, 10'h0cb: c.level = `LVL_3V33;
      10'h130: c.level = `LVL_4V00; // 304
      10'h068, 10'h069, 10'h06a, 10'h12e, 10'h12f:
      begin
        c.cls = alarm_pkg::CLS_CAL;
        c.level = `LVL_5V33;
      end
      10'h0d3:
      begin
        c.cls = alarm_pkg::CLS_CAL;
        c.level = `LVL_6V00; // 211
      end
      10'h06f:
      begin
        c.cls = alarm_pkg::CLS_CONFIG;
        c.level = `LVL_6V66;
      end
      10'h070:
      begin
        c.cls = alarm_pkg::CLS_CONFIG;
        c.level = `LVL_7V33;
      end
      10'h071, 10'h072:
      begin
        c.cls = alarm_pkg::CLS_CONFIG;
        c.level = `LVL_8V00;
      end
      10'h073, 10'h074:
      begin
        c.cls = alarm_pkg::CLS_CONFIG; // 115/116 blink as warnings
        c.level = `LVL_8V66;
      end
      default: c.level = `LVL_4V66; // 9xx and unlisted
    endcase
    return c;
  endfunction

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        r[i*8 +: 8] = data[i*8 +: 8];
    end
    return r;
  endfunction

  // classification of the registered error state
  always_comb
  begin
    cur = classify(st.err_code);
    warn_cls = st.err_active && (cur.cls == alarm_pkg::CLS_CAL ||
                                 cur.cls == alarm_pkg::CLS_CONFIG);
    fault_now = st.err_active && (cur.cls == alarm_pkg::CLS_FAULT ||
                                  st.escalated || START);
    tick = (st.tick_cnt >= st.presc - 32'h1);
  end

  // next state: bus slave, error latch, timing and outputs
  always_comb
  begin
    logic energize;
    logic [11:0] err_dac;
    logic [7:0] a;
    logic time_wr;
    energize = 1'b0;
    err_dac = 12'h000;
    a = 8'h00;
    time_wr = 1'b0;
    next_st = st;
    next_st.clear_pulse = 1'b0;

    // write channel: address and data taken in either order
    if (S_AXI_AWVALID && S_AXI_AWREADY)
    begin
      next_st.aw_held = 1'b1;
      next_st.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY)
    begin
      next_st.w_held = 1'b1;
      next_st.wdata = S_AXI_WDATA;
      next_st.wstrb = S_AXI_WSTRB;
    end
    if (st.bvalid && S_AXI_BREADY)
      next_st.bvalid = 1'b0;
    if (st.aw_held && st.w_held && !st.bvalid)
    begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = `RESP_OKAY;
      a = {st.awaddr[7:2], 2'b00};
      case (a)
        `REG_CTRL:
        begin
          if (st.wstrb[0])
          begin
            next_st.relay_invert = st.wdata[`CTRL_INVERT];
            next_st.clear_req = st.wdata[`CTRL_CLEAR];
          end
        end
        `REG_PRESCALE:
          next_st.presc = merge(st.presc, st.wdata, st.wstrb);
        `REG_TIME:
        begin
          next_st.seconds = merge(st.seconds, st.wdata, st.wstrb);
          next_st.time_valid = 1'b1; // clock set, stamps valid again
          time_wr = 1'b1;
        end
        `REG_STATUS, `REG_CODE, `REG_STAMP: ; // read-only, ignored
        default: next_st.bresp = `RESP_SLVERR;
      endcase
    end

    // read channel: one read at a time, answer on the next edge
    if (st.rvalid && S_AXI_RREADY)
      next_st.rvalid = 1'b0;
    if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp = `RESP_OKAY;
      next_st.rdata = 32'h0;
      case ({S_AXI_ARADDR[7:2], 2'b00})
        `REG_CTRL:
        begin
          next_st.rdata[`CTRL_INVERT] = st.relay_invert;
          next_st.rdata[`CTRL_CLEAR] = st.clear_req;
        end
        `REG_STATUS:
        begin
          next_st.rdata[`ST_ALARM] = st.pd.alarm_flag;
          next_st.rdata[`ST_WARNING] = st.pd.warning_flag;
          next_st.rdata[`ST_LED] = st.led;
          next_st.rdata[`ST_RELAY] = st.relay;
          next_st.rdata[`ST_TIME_OK] = st.time_valid;
          next_st.rdata[`ST_STAMP_OK] = st.stamp_ok;
        end
        `REG_CODE: next_st.rdata[9:0] = st.pd.code;
        `REG_PRESCALE: next_st.rdata = st.presc;
        `REG_TIME: next_st.rdata = st.seconds;
        `REG_STAMP: next_st.rdata = st.stamp;
        default: next_st.rresp = `RESP_SLVERR;
      endcase
    end

    // error clear finishes on the falling edge of the reset bit
    next_st.clear_prev = st.clear_req;
    if (st.clear_prev && !st.clear_req)
    begin
      next_st.err_active = 1'b0;
      next_st.escalated = 1'b0;
      next_st.clear_pulse = 1'b1;
    end
    // a new error in the clearing cycle wins over the clear
    if (ERROR_VALID)
    begin
      next_st.err_active = 1'b1;
      next_st.err_code = ERROR_CODE;
    end
    // escalation only sticks to an error that survives this edge
    if (warn_cls && START && next_st.err_active)
      next_st.escalated = 1'b1;

    // eighth-second tick; phase bits give 4 Hz and 1 Hz
    if (tick)
    begin
      next_st.tick_cnt = 32'h0;
      next_st.phase = st.phase + 3'h1;
      // a software time set wins over the seconds carry
      if (st.phase == `PHASE_LAST && !time_wr)
        next_st.seconds = st.seconds + 32'h1;
    end
    else
      next_st.tick_cnt = st.tick_cnt + 32'h1;
    // loss of the backup charge beats a simultaneous set
    if (CLOCK_LOST)
      next_st.time_valid = 1'b0;

    // every logged message carries the current time
    if (LOG_STROBE)
    begin
      next_st.stamp = st.seconds;
      next_st.stamp_ok = st.time_valid;
    end

    // LED: steady for faults, blink for warnings
    if (!st.err_active)
      next_st.led = 1'b0;
    else if (fault_now)
      next_st.led = 1'b1;
    else if (cur.cls == alarm_pkg::CLS_CAL)
      next_st.led = st.phase[`PHASE_FAST];
    else
      next_st.led = st.phase[`PHASE_SLOW];

    // relay energized for faults or a warning under start
    energize = fault_now;
    if (st.err_active)
      next_st.relay = energize ^ st.relay_invert;
    else
      next_st.relay = st.relay_invert;

    // analog output: temperature, or the coded error level
    err_dac = 12'(cur.level * `DAC_STEP);
    if (!st.err_active)
      next_st.level = TEMP_LEVEL;
    else if (fault_now || st.phase[`PHASE_SLOW])
      next_st.level = err_dac;
    else
      next_st.level = `DAC_FULL;

    // cyclic status word and error code
    next_st.pd.alarm_flag = st.err_active;
    next_st.pd.warning_flag = warn_cls && !fault_now;
    next_st.pd.code = st.err_active ? st.err_code : 10'h000;
  end

  // one register stage holds the whole block state
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      st <= '0;
      st.presc <= 32'(TICK_CYCLES);
    end
    else
      st <= next_st;
  end

  // ready terms are combinational, data from the state
  assign S_AXI_AWREADY = !st.aw_held;
  assign S_AXI_WREADY = !st.w_held;
  assign S_AXI_BVALID = st.bvalid;
  assign S_AXI_BRESP = st.bresp;
  assign S_AXI_ARREADY = !st.rvalid;
  assign S_AXI_RVALID = st.rvalid;
  assign S_AXI_RDATA = st.rdata;
  assign S_AXI_RRESP = st.rresp;
  assign ALARM_LED = st.led;
  assign ALARM_RELAY = st.relay;
  assign ACTUAL_LEVEL = st.level;
  assign PROCESS_DATA = st.pd;
  assign ERROR_CLEAR = st.clear_pulse;
  assign LOG_STAMP = st.stamp;
  assign LOG_STAMP_OK = st.stamp_ok;

  sequence clear_drop;
    st.clear_req ##1 (!st.clear_req && !ERROR_VALID);
  endsequence

  sequence warn_quiet;
    warn_cls && !START && !st.escalated;
  endsequence

  a_fault_led_on: assert property (
    (st.err_active && cur.cls == alarm_pkg::CLS_FAULT) |=> ALARM_LED)
    else $error("fault without steady LED");
  a_fast_blink: assert property (
    (warn_quiet and cur.cls == alarm_pkg::CLS_CAL)
      |=> ALARM_LED == $past(st.phase[`PHASE_FAST]))
    else $error("fast blink wrong");
  a_slow_blink: assert property (
    (warn_quiet and cur.cls == alarm_pkg::CLS_CONFIG)
      |=> ALARM_LED == $past(st.phase[`PHASE_SLOW]))
    else $error("slow blink wrong");
  a_relay_warn_off: assert property (
    (warn_quiet and !st.relay_invert) |=> !ALARM_RELAY)
    else $error("relay on during warning");
  a_relay_inverted: assert property (
    (fault_now && st.relay_invert) |=> !ALARM_RELAY)
    else $error("inverted relay energized on fault");
  a_alarm_flag_set: assert property (
    st.err_active |=> PROCESS_DATA.alarm_flag &&
      PROCESS_DATA.code == $past(st.err_code))
    else $error("alarm flag or code missing");
  a_clear_after_drop: assert property (
    clear_drop |=> !st.err_active ##1 !PROCESS_DATA.alarm_flag)
    else $error("error not cleared after bit dropped");
  a_clear_held: assert property (
    (st.err_active && st.clear_req) |=> st.err_active)
    else $error("cleared while reset bit high");
  a_level_frozen: assert property (
    (st.escalated && !ERROR_VALID)[*3] |-> $stable(ACTUAL_LEVEL))
    else $error("level toggles after start");
  a_level_101: assert property (
    (st.err_active && st.err_code == 10'h065 && fault_now)
      |=> ACTUAL_LEVEL == `DAC_STEP)
    else $error("wrong level for 101");
  a_stamp_taken: assert property (
    LOG_STROBE |=> LOG_STAMP == $past(st.seconds) &&
      LOG_STAMP_OK == $past(st.time_valid))
    else $error("timestamp not captured");

endmodule
`default_nettype wire

// >>> core/alarm_consts.svh
// register offsets, field positions and timing figures of the alarm block
`ifndef ALARM_CONSTS_SVH
`define ALARM_CONSTS_SVH
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_CODE 8'h08
`define REG_PRESCALE 8'h0c
`define REG_TIME 8'h10
`define REG_STAMP 8'h14
`define CTRL_INVERT 0
`define CTRL_CLEAR 1
`define ST_ALARM 0
`define ST_WARNING 1
`define ST_LED 2
`define ST_RELAY 3
`define ST_TIME_OK 4
`define ST_STAMP_OK 5
`define CLK_PERIOD_NS 50
`define TICK_NS 125000000
`define PHASE_FAST 0
`define PHASE_SLOW 2
`define PHASE_LAST 3'h7
`define DAC_STEP 12'h111
`define DAC_FULL 12'hfff
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define LVL_NONE 4'h0
`define LVL_0V66 4'h1
`define LVL_1V33 4'h2
`define LVL_2V00 4'h3
`define LVL_2V66 4'h4
`define LVL_3V33 4'h5
`define LVL_4V00 4'h6
`define LVL_4V66 4'h7
`define LVL_5V33 4'h8
`define LVL_6V00 4'h9
`define LVL_6V66 4'ha
`define LVL_7V33 4'hb
`define LVL_8V00 4'hc
`define LVL_8V66 4'hd
`endif

// >>> core/alarm_pkg.sv
// types shared by the alarm block and its bench
package alarm_pkg;
  typedef enum logic [1:0] {CLS_NONE, CLS_CAL, CLS_CONFIG, CLS_FAULT} cls_t;

  typedef struct packed {
    cls_t cls;
    logic [3:0] level;
  } class_t;

  // cyclic process data seen by the machine controller
  typedef struct packed {
    logic alarm_flag;
    logic warning_flag;
    logic [9:0] code;
  } pd_t;

  typedef struct packed {
    logic aw_held;
    logic [7:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic relay_invert;
    logic clear_req;
    logic clear_prev;
    logic err_active;
    logic [9:0] err_code;
    logic escalated;
    logic [31:0] presc;
    logic [31:0] tick_cnt;
    logic [2:0] phase;
    logic [31:0] seconds;
    logic time_valid;
    logic [31:0] stamp;
    logic stamp_ok;
    logic clear_pulse;
    logic led;
    logic relay;
    logic [11:0] level;
    pd_t pd;
  } state_t;
endpackage

// >>> test/machine_ctrl_model.sv
// fieldbus-side machine controller: drives start, watches the alarm flag
`timescale 1ns/1ps
`default_nettype none
module machine_ctrl_model (
  input wire logic CLK,
  input wire logic RST,
  input wire logic start_req,
  input wire alarm_pkg::pd_t pd,
  output logic START,
  output logic alarm_seen
);
  // start follows the request one edge later, as a cyclic frame would
  always_ff @(posedge CLK)
  begin
    START <= RST ? 1'b0 : start_req;
    // flags are not trusted while the device sits in reset
    alarm_seen <= RST ? 1'b0 : pd.alarm_flag;
  end
endmodule
`default_nettype wire

// >>> test/alarm_error_indication_tb_top.sv
// self-checking bench for the alarm indication block
`timescale 1ns/1ps
`default_nettype none
`include "alarm_consts.svh"
module alarm_error_indication_tb_top;
  logic CLK = 0, RST = 1, ev = 0, sr = 0, ls = 0, cl = 0, st, inv;
  logic [9:0] ec = 0;
  logic [11:0] tl = 0, lvl;
  logic led, relay, clr, ok, awr, wr, bv, arr, rv, seen;
  logic [31:0] stamp, rd, wdata = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [1:0] br, rr, r;
  logic [15:0] seed = 16'hfc7f;
  alarm_pkg::pd_t pd;
  int n_fail = 0, n_compared = 0, nc = 0;
  int codes[29] = '{101, 102, 103, 107, 108, 307, 308, 309, 310, 201, 202,
    203, 304, 901, 913, 914, 915, 916, 917, 918, 104, 105, 106, 302, 303,
    211, 111, 112, 113};
  // level index per code; 0.66 V steps, coded as k * 0x111
  int ks[29] = '{1, 2, 3, 4, 4, 4, 4, 4, 4, 5, 5, 5, 6, 7, 7, 7, 7, 7,
    7, 7, 8, 8, 8, 8, 8, 9, 10, 11, 12};

  always #25 CLK = ~CLK;
  // counts completed clears; a one-cycle pulse is easy to miss otherwise
  always @(posedge CLK) if (clr === 1'b1) nc <= nc + 1;

  machine_ctrl_model partner (.CLK(CLK), .RST(RST), .start_req(sr),
    .pd(pd), .START(st), .alarm_seen(seen));

  alarm_error_indication #(.TICK_CYCLES(4)) DUT (.CLK(CLK), .RST(RST),
    .ERROR_CODE(ec), .ERROR_VALID(ev), .START(st), .TEMP_LEVEL(tl),
    .LOG_STROBE(ls), .CLOCK_LOST(cl), .ALARM_LED(led), .ALARM_RELAY(relay),
    .ACTUAL_LEVEL(lvl), .PROCESS_DATA(pd), .ERROR_CLEAR(clr),
    .LOG_STAMP(stamp), .LOG_STAMP_OK(ok), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wr),
    .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rready));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // blink transitions seen in a 64-cycle window at a 4-cycle tick
  function automatic int exp_blinks(input int k);
    return (k < 10) ? 16 : 4;
  endfunction

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chkv(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  // a wait that ran out of its bound ends the run
  task automatic tmo(input int n);
    if (n >= 30)
    begin
      n_fail++;
      $display("Error wait: expected answer, seen none");
      end_of_test();
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ad, wd;
    @(posedge CLK);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    ad = 0;
    wd = 0;
    n = 0;
    do
    begin
      @(posedge CLK);
      n++;
      if (awr === 1'b1 && !ad)
      begin
        ad = 1;
        awvalid <= 0;
      end
      if (wr === 1'b1 && !wd)
      begin
        wd = 1;
        wvalid <= 0;
      end
    end while (!(ad && wd) && n < 30);
    tmo(n);
    n = 0;
    do
    begin
      @(posedge CLK);
      n++;
    end while (bv !== 1'b1 && n < 30);
    r = br;
    bready <= 0;
    tmo(n);
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d);
    int n;
    @(posedge CLK);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    n = 0;
    do
    begin
      @(posedge CLK);
      n++;
    end while (arr !== 1'b1 && n < 30);
    arvalid <= 0;
    tmo(n);
    n = 0;
    do
    begin
      @(posedge CLK);
      n++;
    end while (rv !== 1'b1 && n < 30);
    d = rd;
    r = rr;
    rready <= 0;
    tmo(n);
  endtask

  // one error code from injection through escalation (warning codes only) to clear
  task automatic run_code(input logic [9:0] c, input int k);
    logic [11:0] lv;
    logic [31:0] d;
    logic w, p;
    int t, nf, ne;
    lv = 12'(k) * 12'h111;
    w = k >= 8;
    seed = lfsr(seed);
    inv = seed[0];
    tl <= seed[15:4];
    axw(`REG_CTRL, {31'h0, inv});
    @(posedge CLK);
    ev <= 1;
    ec <= c;
    @(posedge CLK);
    ev <= 0;
    repeat (3) @(posedge CLK);
    chkv("code", c, pd.code);
    chkv("alarm", 1, pd.alarm_flag);
    chkv("warning", w, pd.warning_flag);
    axr(`REG_CODE, d);
    chkv("code reg", c, d[9:0]);
    if (!w)
    begin
      chkv("level", lv, lvl);
      chkv("led", 1, led);
      chkv("relay", !inv, relay);
      axr(`REG_STATUS, d);
      chkv("status alarm", 1, d[`ST_ALARM]);
      chkv("status led", 1, d[`ST_LED]);
      chkv("status relay", !inv, d[`ST_RELAY]);
    end
    else
    begin
      chkv("relay", inv, relay);
      p = led;
      t = 0;
      nf = 0;
      ne = 0;
      // both halves of the 1 Hz toggle last exactly 16 cycles here
      repeat (64)
      begin
        @(posedge CLK);
        if (led !== p) t++;
        p = led;
        if (lvl === 12'hfff) nf++;
        if (lvl === lv) ne++;
      end
      chkv("blinks", exp_blinks(k), t);
      chkv("full scale", 32, nf);
      chkv("err level", 32, ne);
      sr <= 1;
      repeat (4) @(posedge CLK);
      chkv("start level", lv, lvl);
      chkv("start led", 1, led);
      chkv("start relay", !inv, relay);
    end
    sr <= 0;
    nc = 0;
    axw(`REG_CTRL, {30'h0, 1'b1, inv});
    repeat (4) @(posedge CLK);
    chkv("held", 1, pd.alarm_flag);
    chkv("early clear", 0, nc);
    axw(`REG_CTRL, {31'h0, inv});
    t = 0;
    while (nc == 0 && t < 30)
    begin
      @(posedge CLK);
      t++;
    end
    tmo(t);
    repeat (2) @(posedge CLK);
    chkv("clear pulses", 1, nc);
    chkv("cleared", 0, pd.alarm_flag);
    chkv("idle level", tl, lvl);
    chkv("idle relay", inv, relay);
  endtask

  initial
  begin
    logic [31:0] d;
    repeat (6) @(posedge CLK);
    RST <= 0;
    axr(`REG_PRESCALE, d);
    chkv("prescale", 4, d);
    axr(8'h18, d);
    chkv("unmapped", `RESP_SLVERR, r);
    axw(`REG_STATUS, 32'hffffffff);
    chkv("ro write", `RESP_OKAY, r);
    for (int i = 0; i < 29; i++)
      run_code(10'(codes[i]), ks[i]);
    run_code(10'd114, 12);
    run_code(10'd116, 13);
    // supply interruption in mid-run: reset alone drops a latched fault
    @(posedge CLK);
    ev <= 1;
    ec <= 10'd901;
    @(posedge CLK);
    ev <= 0;
    repeat (3) @(posedge CLK);
    chkv("seen", 1, seen);
    RST <= 1;
    repeat (3) @(posedge CLK);
    RST <= 0;
    @(posedge CLK);
    chkv("power clear", 0, pd.alarm_flag);
    chkv("seen in reset", 0, seen);
    axr(`REG_PRESCALE, d);
    chkv("prescale again", 4, d);
    seed = lfsr(seed);
    axw(`REG_TIME, {16'h0, seed});
    @(posedge CLK);
    ls <= 1;
    @(posedge CLK);
    ls <= 0;
    repeat (2) @(posedge CLK);
    chkv("stamp ok", 1, ok);
    chkv("stamp near", 1, (stamp - {16'h0, seed}) <= 1);
    cl <= 1;
    @(posedge CLK);
    cl <= 0;
    ls <= 1;
    @(posedge CLK);
    ls <= 0;
    repeat (2) @(posedge CLK);
    chkv("stamp lost", 0, ok);
    axr(`REG_STATUS, d);
    chkv("time valid", 0, d[`ST_TIME_OK]);
    end_of_test();
  end
endmodule
`default_nettype wire
